// ===== rtl/ivm_pkg.sv
package ivm_pkg;
  localparam int NUM_VEC = 144;
  localparam int VEC_W = 8;
  localparam int PRIO_W = 3;
  localparam int ADDR_W = 24;
  localparam int OFFSET_W = 10;
  localparam logic [OFFSET_W-1:0] TABLE_TOP = 10'h3fc;
  localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h7;
  localparam logic [VEC_W-1:0] VEC_CALL_BASE = 8'h00;
  localparam logic [VEC_W-1:0] VEC_RESET = 8'h08;
  localparam logic [VEC_W-1:0] VEC_TRAP = 8'h09;
  localparam logic [VEC_W-1:0] VEC_UNDEF = 8'h0a;
  localparam logic [VEC_W-1:0] VEC_NMI = 8'h0b;
  localparam logic [VEC_W-1:0] VEC_DELAYED = 8'h0c;
  localparam logic [VEC_W-1:0] VEC_FIRST_PRIO = 8'h0c;
  localparam logic [VEC_W-1:0] VEC_RC_TICK = 8'h0d;
  localparam logic [VEC_W-1:0] VEC_MAIN_TICK = 8'h0e;
  localparam logic [VEC_W-1:0] VEC_SUB_TICK = 8'h0f;
  localparam logic [VEC_W-1:0] VEC_LOW_VOLT = 8'h10;
  localparam logic [VEC_W-1:0] VEC_EXT_FIRST = 8'h11;
  localparam logic [VEC_W-1:0] VEC_EXT_LAST = 8'h20;
  localparam logic [VEC_W-1:0] VEC_CAN0 = 8'h21;
  localparam logic [VEC_W-1:0] VEC_PG_LO_FIRST = 8'h26;
  localparam logic [VEC_W-1:0] VEC_PG_LO_LAST = 8'h2d;
  localparam logic [VEC_W-1:0] VEC_PG_HI_FIRST = 8'h32;
  localparam logic [VEC_W-1:0] VEC_PG_HI_LAST = 8'h35;
  localparam logic [VEC_W-1:0] VEC_RLT_FIRST = 8'h3a;
  localparam logic [VEC_W-1:0] VEC_RLT_LAST = 8'h3d;
  localparam logic [VEC_W-1:0] VEC_RLT6 = 8'h40;
  localparam logic [VEC_W-1:0] VEC_ICU_FIRST = 8'h41;
  localparam logic [VEC_W-1:0] VEC_ICU_LAST = 8'h48;
  localparam logic [VEC_W-1:0] VEC_OUTPUT_COMPARE = 8'h4d;
  localparam logic [VEC_W-1:0] VEC_SOUND1 = 8'h79;
  localparam logic [VEC_W-1:0] VEC_FLASH_A = 8'h85;
  localparam logic [VEC_W-1:0] VEC_RANGE_CMP = 8'h8b;
  localparam logic [VEC_W-1:0] VEC_PULSE_DET = 8'h8c;

  function automatic logic [OFFSET_W-1:0] vec_offset(input logic [VEC_W-1:0] v);
    return TABLE_TOP - {v[OFFSET_W-3:0], 2'h0};
  endfunction

  function automatic logic in_range(input logic [VEC_W-1:0] v,
                                    input logic [VEC_W-1:0] lo,
                                    input logic [VEC_W-1:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic logic dma_clearable(input logic [VEC_W-1:0] v);
    return in_range(v, VEC_EXT_FIRST, VEC_EXT_LAST) ||
           in_range(v, VEC_PG_LO_FIRST, VEC_PG_LO_LAST) ||
           in_range(v, VEC_PG_HI_FIRST, VEC_PG_HI_LAST) ||
           in_range(v, VEC_RLT_FIRST, VEC_RLT_LAST) ||
           (v == VEC_RLT6) || in_range(v, VEC_ICU_FIRST, VEC_ICU_LAST) ||
           (v == VEC_OUTPUT_COMPARE) || (v == VEC_FLASH_A);
  endfunction
endpackage

// ===== rtl/vector_arbiter.sv
`timescale 1ns/1ps
module vector_arbiter
  import ivm_pkg::*;
#(
  parameter int N = NUM_VEC
) (
  // Pending requests and their levels
  input wire logic [N-1:0] pend,
  input wire logic [N*ivm_pkg::PRIO_W-1:0] prio,
  // Winner
  output logic found,
  output logic [ivm_pkg::VEC_W-1:0] vec,
  output logic [ivm_pkg::PRIO_W-1:0] level
);
  import ivm_pkg::*;

  // Lowest level value wins; strict compare keeps the lowest vector on ties
  always_comb begin
    found = 1'b0;
    vec = VEC_FIRST_PRIO;
    level = PRIO_OFF;
    for (int i = int'(VEC_FIRST_PRIO); i < N; i++) begin
      if (pend[i] && (prio[i*PRIO_W +: PRIO_W] < level)) begin
        found = 1'b1;
        vec = VEC_W'(i);
        level = prio[i*PRIO_W +: PRIO_W];
      end
    end
  end
endmodule

// ===== rtl/interrupt_vector_map.sv
// Functional notes
// - Vector n entry sits at offset 3fc minus four times n.
// - From vector 12 up, priority index equals the vector number.
// - Delayed interrupt uses vector 12, not DMA-clearable.
// - Oscillator ticks request 13 to 15, low voltage 16; no DMA clear.
// - External inputs 0 to 15 request 17 to 32; DMA-clearable.
// - CAN controller 0 requests vector 33; not DMA-clearable.
// - Pulse generators 0-7 on 38-45, 12-15 on 50-53; DMA-clearable.
// - Reload timers 0-3 on 58-61, timer 6 on 64; DMA-clearable.
// - Input capture 0-7 on 65-72, output compare 0 on 77; DMA-clearable.
// - Sound generator 1 requests vector 121; not DMA-clearable.
// - Flash bank A requests vector 133; DMA-clearable.
// - Converter range compare on 139, pulse detect on 140; no DMA clear.
// - Reserved vectors have no source and no DMA clear.
`timescale 1ns/1ps
module interrupt_vector_map
  import ivm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Peripheral sources
  input wire logic delayed_irq,
  input wire logic rc_osc_tick,
  input wire logic main_osc_tick,
  input wire logic sub_osc_tick,
  input wire logic low_voltage_irq,
  input wire logic [15:0] external_irq,
  input wire logic can0_irq,
  input wire logic [7:0] pulse_gen_lo,
  input wire logic [3:0] pulse_gen_hi,
  input wire logic [3:0] reload_timer_lo,
  input wire logic reload_timer6,
  input wire logic [7:0] input_capture,
  input wire logic output_compare0,
  input wire logic sound_gen1,
  input wire logic flash_bank_a_irq,
  input wire logic converter_range_cmp,
  input wire logic converter_pulse_det,
  input wire logic nmi_in,
  // Priority levels, one field per vector index
  input wire logic [ivm_pkg::NUM_VEC*ivm_pkg::PRIO_W-1:0] priority_ctrl_reg,
  // Core side
  input wire logic [ivm_pkg::PRIO_W-1:0] core_ilm,
  input wire logic core_ack,
  input wire logic vector_call_instr,
  input wire logic [2:0] call_idx,
  input wire logic software_trap,
  input wire logic undef_instr,
  input wire logic [ivm_pkg::ADDR_W-1:0] vector_table_base,
  output logic irq_req,
  output logic fetch_valid,
  output logic [ivm_pkg::VEC_W-1:0] fetch_vec,
  output logic [ivm_pkg::ADDR_W-1:0] fetch_addr,
  // DMA side
  input wire logic dma_clear_req,
  input wire logic [ivm_pkg::VEC_W-1:0] dma_clear_vec,
  output logic dma_cleared
);
  import ivm_pkg::*;

  logic [NUM_VEC-1:0] pend_reg, pend_next, src, clr;
  logic boot_reg, nmi_pend_reg;
  logic fetch_valid_reg;
  logic [VEC_W-1:0] fetch_vec_reg;
  logic [ADDR_W-1:0] fetch_addr_reg;
  logic arb_found;
  logic [VEC_W-1:0] arb_vec;
  logic [PRIO_W-1:0] arb_level;

  vector_arbiter #(.N(NUM_VEC)) u_arb (
    .pend(pend_reg),
    .prio(priority_ctrl_reg),
    .found(arb_found),
    .vec(arb_vec),
    .level(arb_level)
  );

  // Reserved and fixed vectors stay tied low, so nothing can pend there
  always_comb begin
    src = '0;
    src[VEC_DELAYED] = delayed_irq;
    src[VEC_RC_TICK] = rc_osc_tick;
    src[VEC_MAIN_TICK] = main_osc_tick;
    src[VEC_SUB_TICK] = sub_osc_tick;
    src[VEC_LOW_VOLT] = low_voltage_irq;
    src[VEC_CAN0] = can0_irq;
    for (int i = 0; i < 16; i++) src[int'(VEC_EXT_FIRST) + i] = external_irq[i];
    for (int i = 0; i < 8; i++) src[int'(VEC_PG_LO_FIRST) + i] = pulse_gen_lo[i];
    for (int i = 0; i < 4; i++) src[int'(VEC_PG_HI_FIRST) + i] = pulse_gen_hi[i];
    for (int i = 0; i < 4; i++) src[int'(VEC_RLT_FIRST) + i] = reload_timer_lo[i];
    src[VEC_RLT6] = reload_timer6;
    for (int i = 0; i < 8; i++) src[int'(VEC_ICU_FIRST) + i] = input_capture[i];
    src[VEC_OUTPUT_COMPARE] = output_compare0;
    src[VEC_SOUND1] = sound_gen1;
    src[VEC_FLASH_A] = flash_bank_a_irq;
    src[VEC_RANGE_CMP] = converter_range_cmp;
    src[VEC_PULSE_DET] = converter_pulse_det;
  end

  wire irq_ok = arb_found && (arb_level < core_ilm);
  wire sync_fetch = boot_reg || undef_instr || software_trap || vector_call_instr;
  // Synchronous fetches outrank an acknowledge; the core retries its ack later
  wire take_nmi = core_ack && !sync_fetch && nmi_pend_reg;
  wire take_irq = core_ack && !sync_fetch && !nmi_pend_reg && irq_ok;
  wire take_any = sync_fetch || take_nmi || take_irq;
  wire dma_ok = dma_clear_req && (dma_clear_vec < VEC_W'(NUM_VEC)) &&
                dma_clearable(dma_clear_vec);
  wire [VEC_W-1:0] sel_vec = boot_reg ? VEC_RESET :
                             undef_instr ? VEC_UNDEF :
                             software_trap ? VEC_TRAP :
                             vector_call_instr ? (VEC_CALL_BASE | {5'h00, call_idx}) :
                             take_nmi ? VEC_NMI : arb_vec;
  wire [ADDR_W-1:0] addr_next = vector_table_base +
                                {{(ADDR_W-OFFSET_W){1'b0}}, vec_offset(sel_vec)};

  always_comb begin
    clr = '0;
    if (take_irq) clr[arb_vec] = 1'b1;
    if (dma_ok) clr[dma_clear_vec] = 1'b1;
  end
  // New events win over a clear in the same cycle
  assign pend_next = (pend_reg & ~clr) | src;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pend_reg <= '0;
      nmi_pend_reg <= 1'b0;
      boot_reg <= 1'b1;
    end else begin
      pend_reg <= pend_next;
      nmi_pend_reg <= nmi_in || (nmi_pend_reg && !take_nmi);
      boot_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fetch_valid_reg <= 1'b0;
      fetch_vec_reg <= '0;
      fetch_addr_reg <= '0;
    end else begin
      fetch_valid_reg <= take_any;
      if (take_any) begin
        fetch_vec_reg <= sel_vec;
        fetch_addr_reg <= addr_next;
      end
    end
  end

  assign irq_req = nmi_pend_reg || irq_ok;
  assign fetch_valid = fetch_valid_reg;
  assign fetch_vec = fetch_vec_reg;
  assign fetch_addr = fetch_addr_reg;
  assign dma_cleared = dma_ok;

  property p_addr;
    @(posedge clk) disable iff (!rst_b)
    take_any |=> fetch_addr_reg == $past(vector_table_base) +
      {{(ADDR_W-OFFSET_W){1'b0}}, TABLE_TOP - {fetch_vec_reg[OFFSET_W-3:0], 2'h0}};
  endproperty
  a_addr: assert property (p_addr) else $error("fetch address wrong");

  property p_boot;
    @(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |=> fetch_valid_reg && (fetch_vec_reg == 8'h08);
  endproperty
  a_boot: assert property (p_boot) else $error("no reset vector fetch");

  property p_trap;
    @(posedge clk) disable iff (!rst_b)
    software_trap && !boot_reg && !undef_instr |=> fetch_valid_reg && fetch_vec_reg == 8'h09;
  endproperty
  a_trap: assert property (p_trap) else $error("trap vector wrong");

  property p_call;
    @(posedge clk) disable iff (!rst_b)
    vector_call_instr && !boot_reg && !undef_instr && !software_trap
      |=> fetch_valid_reg && fetch_vec_reg == {5'h00, $past(call_idx)};
  endproperty
  a_call: assert property (p_call) else $error("call vector wrong");

  property p_arb_floor;
    @(posedge clk) disable iff (!rst_b)
    arb_found |-> arb_vec >= 8'h0c && priority_ctrl_reg[arb_vec*PRIO_W +: PRIO_W] != 3'h7;
  endproperty
  a_arb_floor: assert property (p_arb_floor) else $error("bad arbitration");

  property p_ext;
    @(posedge clk) disable iff (!rst_b)
    external_irq[15] |=> pend_reg[32];
  endproperty
  a_ext: assert property (p_ext) else $error("external 15 not pending");

  property p_sound;
    @(posedge clk) disable iff (!rst_b)
    sound_gen1 ##1 (dma_clear_req && dma_clear_vec == 8'h79) |-> !dma_cleared;
  endproperty
  a_sound: assert property (p_sound) else $error("sound request DMA-cleared");

  property p_reserved;
    @(posedge clk) disable iff (!rst_b)
    pend_reg[11:0] == 12'h000 && pend_reg[37:34] == 4'h0 && pend_reg[143:141] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved vector pending");

  property p_dma_clear;
    @(posedge clk) disable iff (!rst_b)
    dma_cleared && !src[dma_clear_vec] |=> !pend_reg[$past(dma_clear_vec)];
  endproperty
  a_dma_clear: assert property (p_dma_clear) else $error("DMA clear lost");

  property p_dma_none;
    @(posedge clk) disable iff (!rst_b)
    dma_clear_req && (dma_clear_vec == 8'h0c || dma_clear_vec == 8'h21 ||
      dma_clear_vec == 8'h8b) |-> !dma_cleared;
  endproperty
  a_dma_none: assert property (p_dma_none) else $error("non-clearable cleared");

  property p_cov_irq;
    @(posedge clk) disable iff (!rst_b) take_irq ##1 fetch_valid_reg;
  endproperty
  c_irq: cover property (p_cov_irq);
  property p_cov_nmi;
    @(posedge clk) disable iff (!rst_b) take_nmi;
  endproperty
  c_nmi: cover property (p_cov_nmi);
  property p_cov_dma;
    @(posedge clk) disable iff (!rst_b) dma_cleared;
  endproperty
  c_dma: cover property (p_cov_dma);
endmodule

// ===== tb/core_model.sv
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request and acknowledge
  input wire logic irq_req,
  input wire logic [3:0] wait_cycles,
  output logic core_ack
);
  logic [3:0] cnt_reg;
  initial begin
    core_ack = 1'b0;
    cnt_reg = 4'h0;
  end
  // A slow core lets a DMA clear land before the acknowledge
  always @(posedge clk) begin
    if (!rst_b || irq_req !== 1'b1 || core_ack) begin
      cnt_reg <= #1 4'h0;
      core_ack <= #1 1'b0;
    end else if (cnt_reg >= wait_cycles) begin
      core_ack <= #1 1'b1;
    end else begin
      cnt_reg <= #1 cnt_reg + 4'h1;
    end
  end
endmodule

// ===== tb/test_interrupt_vector_map.sv
`timescale 1ns/1ps
module test_interrupt_vector_map;
  import ivm_pkg::*;
  logic clk, rst_b, nmi_in, core_ack, vector_call_instr, software_trap, undef_instr;
  logic dma_clear_req, dma_cleared, irq_req, fetch_valid;
  logic [2:0] call_idx;
  logic [3:0] wait_cycles;
  logic [PRIO_W-1:0] core_ilm;
  logic [143:0] src;
  logic [NUM_VEC*PRIO_W-1:0] prio_r;
  logic [ADDR_W-1:0] base, fetch_addr;
  logic [VEC_W-1:0] dma_clear_vec, fetch_vec;
  int miscompares, total_checks;
  // Vector in the low byte, bit 8 set where DMA may clear it
  logic [8:0] rows [22] = '{9'h00c, 9'h00d, 9'h00e, 9'h00f, 9'h010, 9'h111, 9'h120,
    9'h021, 9'h126, 9'h12d, 9'h132, 9'h135, 9'h13a, 9'h13d, 9'h140, 9'h141, 9'h148,
    9'h14d, 9'h079, 9'h185, 9'h08b, 9'h08c};

  interrupt_vector_map DUT (.clk(clk), .rst_b(rst_b), .delayed_irq(src[12]),
    .rc_osc_tick(src[13]), .main_osc_tick(src[14]), .sub_osc_tick(src[15]),
    .low_voltage_irq(src[16]), .external_irq(src[32:17]), .can0_irq(src[33]),
    .pulse_gen_lo(src[45:38]), .pulse_gen_hi(src[53:50]), .reload_timer_lo(src[61:58]),
    .reload_timer6(src[64]), .input_capture(src[72:65]), .output_compare0(src[77]),
    .sound_gen1(src[121]), .flash_bank_a_irq(src[133]), .converter_range_cmp(src[139]),
    .converter_pulse_det(src[140]), .nmi_in(nmi_in), .priority_ctrl_reg(prio_r),
    .core_ilm(core_ilm), .core_ack(core_ack), .vector_call_instr(vector_call_instr),
    .call_idx(call_idx), .software_trap(software_trap), .undef_instr(undef_instr),
    .vector_table_base(base), .irq_req(irq_req), .fetch_valid(fetch_valid),
    .fetch_vec(fetch_vec), .fetch_addr(fetch_addr), .dma_clear_req(dma_clear_req),
    .dma_clear_vec(dma_clear_vec), .dma_cleared(dma_cleared));

  core_model core (.clk(clk), .rst_b(rst_b), .irq_req(irq_req),
    .wait_cycles(wait_cycles), .core_ack(core_ack));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic cyc();
    @(posedge clk);
    #1;
  endtask

  function automatic logic [ADDR_W-1:0] exp_addr(input logic [VEC_W-1:0] v);
    return base + 24'h0003fc - {14'h0000, v, 2'h0};
  endfunction

  task automatic chk(input logic ok, input string what);
    total_checks++;
    if (!ok) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic wait_fetch(input logic [VEC_W-1:0] v);
    int n;
    n = 0;
    while (fetch_valid !== 1'b1 && n < 20) begin
      cyc();
      n++;
    end
    chk(fetch_valid === 1'b1 && fetch_vec === v && fetch_addr === exp_addr(v), "fetch");
    cyc();
  endtask

  task automatic pulse_src(input int v);
    src[v] = 1'b1;
    cyc();
    src[v] = 1'b0;
  endtask

  task automatic dma(input logic [VEC_W-1:0] v, input logic e);
    dma_clear_vec = v;
    dma_clear_req = 1'b1;
    #1;
    chk(dma_cleared === e, "dma clear answer");
    cyc();
    dma_clear_req = 1'b0;
    // Let an edge pass so a following request never re-raises in the same step
    cyc();
  endtask

  task automatic complete_run();
    $display("Checks: %0d, mismatches: %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial begin
    {rst_b, nmi_in, vector_call_instr, software_trap, undef_instr, dma_clear_req} = '0;
    call_idx = 3'h0;
    wait_cycles = 4'h0;
    core_ilm = 3'h7;
    src = '0;
    prio_r = '0;
    base = 24'h0f0000;
    dma_clear_vec = 8'h00;
    miscompares = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    #1;
    chk(fetch_valid === 1'b0 && fetch_vec === 8'h00 && irq_req === 1'b0, "reset state");
    rst_b = 1'b1;
    wait_fetch(8'h08);
    for (int i = 0; i < 22; i++) begin
      dma(rows[i][7:0], rows[i][8]);
      pulse_src(rows[i][7:0]);
      wait_fetch(rows[i][7:0]);
    end
    base = 24'h123400;
    for (int i = 0; i < 8; i++) begin
      call_idx = 3'(i);
      vector_call_instr = 1'b1;
      cyc();
      vector_call_instr = 1'b0;
      wait_fetch(8'(i));
    end
    software_trap = 1'b1;
    cyc();
    software_trap = 1'b0;
    wait_fetch(8'h09);
    undef_instr = 1'b1;
    cyc();
    undef_instr = 1'b0;
    wait_fetch(8'h0a);
    nmi_in = 1'b1;
    cyc();
    nmi_in = 1'b0;
    wait_fetch(8'h0b);
    dma(8'h22, 1'b0);
    dma(8'h0c, 1'b0);
    wait_cycles = 4'h8;
    core_ilm = 3'h2;
    prio_r[3*17 +: 3] = 3'h2;
    prio_r[3*38 +: 3] = 3'h1;
    pulse_src(17);
    chk(irq_req === 1'b0, "level not below mask");
    pulse_src(38);
    wait_cycles = 4'h0;
    wait_fetch(8'h26);
    core_ilm = 3'h7;
    wait_fetch(8'h11);
    wait_cycles = 4'h8;
    pulse_src(17);
    chk(irq_req === 1'b1, "pending before dma");
    dma(8'h11, 1'b1);
    chk(irq_req === 1'b0, "dma cleared pending");
    pulse_src(33);
    dma(8'h21, 1'b0);
    chk(irq_req === 1'b1, "still pending");
    wait_cycles = 4'h0;
    wait_fetch(8'h21);
    wait_cycles = 4'h8;
    pulse_src(121);
    dma(8'h79, 1'b0);
    chk(irq_req === 1'b1, "sound still pending");
    wait_cycles = 4'h0;
    wait_fetch(8'h79);
    rst_b = 1'b0;
    cyc();
    rst_b = 1'b1;
    wait_fetch(8'h08);
    complete_run();
  end
endmodule
